/* File: pkg/pdt_pkg.sv */
// Constants and types shared by the power domain transition controller files
package pdt_pkg;
	// Register byte offsets
	localparam logic [11:0] PDT_OFF_TRIGGER  = 12'h000; // domain_transition_trigger
	localparam logic [11:0] PDT_OFF_BUSY     = 12'h004; // domain_transition_busy
	localparam logic [11:0] PDT_OFF_STATUS   = 12'h008; // always_on_domain_status
	localparam logic [11:0] PDT_OFF_IRQ_STAT = 12'h00C; // Sticky event flags, write one to clear
	localparam logic [11:0] PDT_OFF_IRQ_MASK = 12'h010; // Event enables
	// Trigger and busy bit positions
	localparam int PDT_AON_BIT = 0;
	localparam int PDT_RAM_BIT = 1;
	// Status word layout
	localparam int PDT_STATE_W      = 5;
	localparam int PDT_POR_BIT      = 8;
	localparam int PDT_DOMAIN_RESET_COMPLETE_BIT  = 9;
	localparam int PDT_DBG_BIT      = 11;
	localparam logic [4:0] PDT_STATE_OFF   = 5'h00;
	localparam logic [4:0] PDT_STATE_ON    = 5'h01;
	localparam logic [4:0] PDT_STATE_TRANS = 5'h10;
	// Event bits in the sticky status and mask registers
	localparam int PDT_IRQ_W        = 3;
	localparam int PDT_IRQ_AON_DONE = 0;
	localparam int PDT_IRQ_RAM_DONE = 1;
	localparam int PDT_IRQ_DBG      = 2;
	localparam logic [2:0] PDT_IRQ_RESET = 3'h0;
	// Sizes and timing counts in pclk cycles
	localparam int PDT_AON_MODS       = 4;
	localparam int PDT_RAM_MODS       = 2;
	localparam int PDT_TRANS_CYCLES   = 4;
	localparam int PDT_POR_REL_CYCLES = 8;
	localparam int PDT_POR_DONE_CYCLES = 16;
	localparam int PDT_CNT_W          = 8;
	// Transition group sequencer
	typedef enum logic [1:0] {
		GRP_IDLE = 2'b00,
		GRP_RUN  = 2'b01,
		GRP_DONE = 2'b11
	} pdt_grp_state_type;
	// Power-on reset sequencer
	typedef enum logic [1:0] {
		POR_HOLD     = 2'b00,
		POR_RELEASED = 2'b01,
		POR_COMPLETE = 2'b11
	} pdt_por_state_type;
endpackage : pdt_pkg

/* File: hw/pdt_group.sv */
// Transition sequencer for one group of domains and modules
`timescale 1ns/100ps
module pdt_group
	import pdt_pkg::*;
#(
	parameter int W            = 2,
	parameter int TRANS_CYCLES = PDT_TRANS_CYCLES
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         go,
	input  wire logic [W-1:0] target,
	output logic      [W-1:0] current,
	output logic              busy,
	output logic              done
);
	// Whole state of the group
	typedef struct packed {
		pdt_grp_state_type    state;
		logic [W-1:0]         current; // Present state of each item, 1 = on
		logic [W-1:0]         mask;    // Items that differed at the trigger
		logic [W-1:0]         target;  // Targets captured at the trigger
		logic [PDT_CNT_W-1:0] cnt;
	} pdt_grp_reg_type;

	pdt_grp_reg_type r_reg;
	pdt_grp_reg_type r_next;
	localparam logic [PDT_CNT_W-1:0] CNT_LAST = PDT_CNT_W'(TRANS_CYCLES - 1);

	// Next state
	always_comb begin
		r_next = r_reg;
		case (r_reg.state)
			GRP_IDLE: begin
				// Only mismatched items move; a zero write never gets here
				if (go && (|(target ^ r_reg.current))) begin
					r_next.mask   = target ^ r_reg.current;
					r_next.target = target;
					r_next.cnt    = '0;
					r_next.state  = GRP_RUN;
				end
			end
			GRP_RUN: begin
				// Triggers while running are not queued; software polls busy first
				if (r_reg.cnt == CNT_LAST) begin
					r_next.current = (r_reg.current & ~r_reg.mask) | (r_reg.target & r_reg.mask);
					r_next.state   = GRP_DONE;
				end else begin
					r_next.cnt = r_reg.cnt + 1'b1;
				end
			end
			GRP_DONE: begin
				r_next.state = GRP_IDLE;
			end
			default: begin
				r_next.state = GRP_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '{GRP_IDLE, '0, '0, '0, '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign current = r_reg.current;
	assign busy    = (r_reg.state != GRP_IDLE);
	assign done    = (r_reg.state == GRP_DONE);

	localparam int BUSY_MAX = 300;

	AST_GRP_BUSY_AFTER_GO: assert property (@(posedge pclk) disable iff (!presetn)
		(go && !busy && (|(target ^ current))) |=> busy)
		else $error("busy did not rise after a mismatching trigger");
	AST_GRP_MATCH_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
		(go && !busy && (target == current)) |=> (!busy && $stable(current)))
		else $error("matching trigger started a transition");
	AST_GRP_REACHED: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(busy) |-> ((current & r_reg.mask) == (r_reg.target & r_reg.mask)))
		else $error("busy cleared before targets were reached");
	AST_GRP_UNTOUCHED: assert property (@(posedge pclk) disable iff (!presetn)
		busy |=> ((current & ~r_reg.mask) == ($past(current) & ~r_reg.mask)))
		else $error("an item outside the transition changed");
	AST_GRP_BOUNDED: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(busy) |-> ##[1:BUSY_MAX] !busy)
		else $error("transition never completed");
endmodule : pdt_group

/* File: hw/pdt_por.sv */
// Power-on reset sequencer for the always-on domain status bits
`timescale 1ns/100ps
module pdt_por
	import pdt_pkg::*;
#(
	parameter int REL_CYCLES  = PDT_POR_REL_CYCLES,
	parameter int DONE_CYCLES = PDT_POR_DONE_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      released,
	output logic      complete
);
	// Whole state of the sequencer
	typedef struct packed {
		pdt_por_state_type    state;
		logic [PDT_CNT_W-1:0] cnt;
	} pdt_por_reg_type;

	pdt_por_reg_type r_reg;
	pdt_por_reg_type r_next;
	localparam logic [PDT_CNT_W-1:0] REL_LAST  = PDT_CNT_W'(REL_CYCLES - 1);
	localparam logic [PDT_CNT_W-1:0] DONE_LAST = PDT_CNT_W'(DONE_CYCLES - 1);

	// Count from reset release through release and completion
	always_comb begin
		r_next = r_reg;
		case (r_reg.state)
			POR_HOLD: begin
				r_next.cnt = r_reg.cnt + 1'b1;
				if (r_reg.cnt == REL_LAST) begin
					r_next.state = POR_RELEASED;
				end
			end
			POR_RELEASED: begin
				r_next.cnt = r_reg.cnt + 1'b1;
				if (r_reg.cnt == DONE_LAST) begin
					r_next.state = POR_COMPLETE;
				end
			end
			POR_COMPLETE: begin
				r_next.cnt = r_reg.cnt; // Sequence ends here until the next reset
			end
			default: begin
				r_next.state = POR_HOLD;
			end
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '{POR_HOLD, '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign released = (r_reg.state != POR_HOLD);
	assign complete = (r_reg.state == POR_COMPLETE);

	AST_POR_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
		complete |-> released)
		else $error("reset done reported while domain reset held");
	AST_POR_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
		released |=> released)
		else $error("domain reset re-asserted without a reset");
endmodule : pdt_por

/* File: hw/pdt_ctrl.sv */
// Power domain transition controller: APB registers, groups, status and interrupt
// Overview of operation
// - Trigger bit 1 examines RAM domain and modules
// - Trigger bit 0 examines always-on modules only
// - Only mismatched items move to their target
// - Writing zero to trigger bits does nothing
// - Busy bit 1 shows RAM domain transitioning
// - Busy bit 0 shows always-on domain transitioning
// - Busy reads zero when transitions have finished
// - State field: 0 off, 1h on, 10h transition
// - Status bit 8 one once domain reset released
// - Status bit 9 one once reset sequence done
// - Status bit 11 flags debug override event
// - Always-on domain always stays on; state field reads off until domain reset released
// - Enable bit gates debug override interrupt
`timescale 1ns/100ps
module pdt_ctrl
	import pdt_pkg::*;
#(
	parameter int AON_MODS     = PDT_AON_MODS,
	parameter int RAM_MODS     = PDT_RAM_MODS,
	parameter int TRANS_CYCLES = PDT_TRANS_CYCLES
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	output logic                     irq,
	input  wire logic [AON_MODS-1:0] aon_mod_next,
	input  wire logic                ram_domain_next,
	input  wire logic [RAM_MODS-1:0] ram_mod_next,
	input  wire logic                debug_override_irq_enable,
	input  wire logic                debug_override_req,
	output logic      [AON_MODS-1:0] aon_mod_state,
	output logic                     ram_domain_state,
	output logic      [RAM_MODS-1:0] ram_mod_state
);
	// Whole state of the top level
	typedef struct packed {
		logic [31:0]          prdata;   // Read data, loaded in the setup cycle
		logic                 pslverr;  // Unmapped address seen in setup
		logic [PDT_IRQ_W-1:0] irq_stat; // Sticky event flags
		logic [PDT_IRQ_W-1:0] irq_mask; // Event enables
		logic                 dbg_s1;   // Synchroniser first stage
		logic                 dbg_s2;   // Synchroniser second stage
		logic                 dbg_s3;   // Edge detect history
	} pdt_top_reg_type;

	pdt_top_reg_type r_reg;
	pdt_top_reg_type r_next;

	// Bus decode
	logic setup;      // First cycle of a transfer
	logic wr_access;  // Write takes effect this edge
	logic mapped;     // Address hits a register
	logic go_aon;     // Trigger pulse, always-on group
	logic go_ram;     // Trigger pulse, RAM group
	logic dbg_event;  // Rising edge of the debug override request
	// Group results
	logic                aon_busy;
	logic                aon_done;
	logic                ram_busy;
	logic                ram_done;
	logic [RAM_MODS:0]   ram_current;
	logic                por_released;
	logic                por_complete;
	// Read views
	logic [4:0]           aon_state;
	logic [31:0]          busy_word;
	logic [31:0]          status_word;
	logic [PDT_IRQ_W-1:0] events;
	logic [PDT_IRQ_W-1:0] irq_gate;

	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign mapped    = (paddr == PDT_OFF_TRIGGER) || (paddr == PDT_OFF_BUSY) || (paddr == PDT_OFF_STATUS)
		|| (paddr == PDT_OFF_IRQ_STAT) || (paddr == PDT_OFF_IRQ_MASK);
	// Only a one in a trigger bit starts anything; zeros and upper bits are dropped
	assign go_aon = wr_access && (paddr == PDT_OFF_TRIGGER) && pwdata[PDT_AON_BIT];
	assign go_ram = wr_access && (paddr == PDT_OFF_TRIGGER) && pwdata[PDT_RAM_BIT];
	// Read only the second and third stages so metastability never reaches logic
	assign dbg_event = r_reg.dbg_s2 && !r_reg.dbg_s3;

	// Always-on modules; the domain itself has no target and stays on
	pdt_group #(
		.W            (AON_MODS),
		.TRANS_CYCLES (TRANS_CYCLES)
	) u_aon_group (
		.pclk    (pclk),
		.presetn (presetn),
		.go      (go_aon),
		.target  (aon_mod_next),
		.current (aon_mod_state),
		.busy    (aon_busy),
		.done    (aon_done)
	);

	// RAM domain: bit 0 is the domain, the rest its modules
	pdt_group #(
		.W            (RAM_MODS + 1),
		.TRANS_CYCLES (TRANS_CYCLES)
	) u_ram_group (
		.pclk    (pclk),
		.presetn (presetn),
		.go      (go_ram),
		.target  ({ram_mod_next, ram_domain_next}),
		.current (ram_current),
		.busy    (ram_busy),
		.done    (ram_done)
	);

	// Always-on domain power-on reset sequence
	pdt_por u_por (
		.pclk     (pclk),
		.presetn  (presetn),
		.released (por_released),
		.complete (por_complete)
	);

	assign ram_domain_state = ram_current[0];
	assign ram_mod_state    = ram_current[RAM_MODS:1];

	// Read words; reserved bits are constant zero
	always_comb begin
		// Off until the domain reset lets go, then on, or transition while busy; never off afterwards
		if (!por_released) begin
			aon_state = PDT_STATE_OFF;
		end else if (aon_busy) begin
			aon_state = PDT_STATE_TRANS;
		end else begin
			aon_state = PDT_STATE_ON;
		end
		busy_word                  = 32'h0000_0000;
		busy_word[PDT_AON_BIT]     = aon_busy;
		busy_word[PDT_RAM_BIT]     = ram_busy;
		status_word                = 32'h0000_0000;
		status_word[PDT_STATE_W-1:0] = aon_state;
		status_word[PDT_POR_BIT]   = por_released;
		status_word[PDT_DOMAIN_RESET_COMPLETE_BIT] = por_complete;
		status_word[PDT_DBG_BIT]   = r_reg.irq_stat[PDT_IRQ_DBG];
	end

	// Events feeding the sticky flags
	always_comb begin
		events                   = PDT_IRQ_RESET;
		events[PDT_IRQ_AON_DONE] = aon_done;
		events[PDT_IRQ_RAM_DONE] = ram_done;
		events[PDT_IRQ_DBG]      = dbg_event;
		// The override event also needs its own domain-level enable
		irq_gate                 = r_reg.irq_mask;
		irq_gate[PDT_IRQ_DBG]    = r_reg.irq_mask[PDT_IRQ_DBG] && debug_override_irq_enable;
	end

	// Next state of registers and bus answer
	always_comb begin
		r_next        = r_reg;
		r_next.dbg_s1 = debug_override_req;
		r_next.dbg_s2 = r_reg.dbg_s1;
		r_next.dbg_s3 = r_reg.dbg_s2;
		// Answer prepared in setup so the zero-wait access finds it in a flop
		if (setup) begin
			r_next.pslverr = !mapped;
			r_next.prdata  = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					PDT_OFF_BUSY: begin
						r_next.prdata = busy_word;
					end
					PDT_OFF_STATUS: begin
						r_next.prdata = status_word;
					end
					PDT_OFF_IRQ_STAT: begin
						r_next.prdata[PDT_IRQ_W-1:0] = r_reg.irq_stat;
					end
					PDT_OFF_IRQ_MASK: begin
						r_next.prdata[PDT_IRQ_W-1:0] = r_reg.irq_mask;
					end
					default: begin
						r_next.prdata = 32'h0000_0000; // Trigger is write-only
					end
				endcase
			end
		end
		// A new event in the clearing cycle survives the clear
		if (wr_access && (paddr == PDT_OFF_IRQ_STAT)) begin
			r_next.irq_stat = (r_reg.irq_stat & ~pwdata[PDT_IRQ_W-1:0]) | events;
		end else begin
			r_next.irq_stat = r_reg.irq_stat | events;
		end
		if (wr_access && (paddr == PDT_OFF_IRQ_MASK)) begin
			r_next.irq_mask = pwdata[PDT_IRQ_W-1:0];
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '{32'h0000_0000, 1'b0, PDT_IRQ_RESET, PDT_IRQ_RESET, 1'b0, 1'b0, 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata  = r_reg.prdata;
	assign pslverr = r_reg.pslverr;
	// Zero wait states: every transfer is setup plus one access cycle,
	// so a master can never use pready to hold off a trigger
	assign pready  = 1'b1;
	assign irq     = |(r_reg.irq_stat & irq_gate);

	// Read of a register, setup then access
	sequence s_read_setup(logic [11:0] off);
		(psel && !penable && !pwrite && (paddr == off));
	endsequence
	sequence s_read_access;
		(psel && penable && !pwrite);
	endsequence

	AST_BUSY_READ: assert property (@(posedge pclk) disable iff (!presetn)
		s_read_setup(PDT_OFF_BUSY) ##1 s_read_access |->
		(prdata[1:0] == {$past(ram_busy), $past(aon_busy)}) && (prdata[31:2] == 30'h0))
		else $error("busy read does not show group busy");
	AST_STATUS_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
		s_read_setup(PDT_OFF_STATUS) ##1 s_read_access |->
		(prdata[31:12] == 20'h0) && (prdata[10] == 1'b0) && (prdata[7:5] == 3'h0))
		else $error("reserved status bits not zero");
	AST_STATE_CODE: assert property (@(posedge pclk) disable iff (!presetn)
		(aon_busy && por_released) |-> (status_word[4:0] == 5'h10))
		else $error("state field not in transition during busy");
	AST_POR_ON: assert property (@(posedge pclk) disable iff (!presetn)
		(por_released && !aon_busy) |-> (status_word[4:0] == 5'h01) && status_word[8])
		else $error("domain not on after reset release");
	AST_ZERO_TRIGGER: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_access && (paddr == PDT_OFF_TRIGGER) && (pwdata[1:0] == 2'b00) && !aon_busy && !ram_busy)
		|=> (!aon_busy && !ram_busy))
		else $error("zero trigger write started a transition");
	AST_DBG_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(debug_override_req) |-> ##3 status_word[11])
		else $error("debug override flag not set");
	AST_DBG_IE: assert property (@(posedge pclk) disable iff (!presetn)
		(!debug_override_irq_enable && (r_reg.irq_stat == 3'h4)) |-> !irq)
		else $error("override interrupt raised while disabled");
	AST_RAM_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
		(go_ram && !ram_busy && ({ram_mod_next, ram_domain_next} != ram_current)) |=> busy_word[1])
		else $error("RAM busy not set after trigger");

	// Checks below watch the bus answer, the groups and the sticky flags.
	// They sample flops, bus inputs and combinational read views at the clock edge, so none races the bus.

	// Trigger has no storage; a read must come back empty
	AST_TRIGGER_READ: assert property (@(posedge pclk) disable iff (!presetn)
		s_read_setup(PDT_OFF_TRIGGER) ##1 s_read_access |-> (prdata == 32'h0000_0000))
		else $error("trigger read returned nonzero data");

	// Error answer follows the decode seen in setup
	AST_BUS_ERROR: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> (pslverr == !$past(mapped)))
		else $error("bus error does not match address decode");

	// Mask keeps only its defined bits
	AST_MASK_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_access && (paddr == PDT_OFF_IRQ_MASK)) |=> (r_reg.irq_mask == PDT_IRQ_W'($past(pwdata))))
		else $error("mask write not taken");

	// Always-on group answers a mismatching trigger next cycle
	AST_AON_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
		(go_aon && !aon_busy && (aon_mod_next != aon_mod_state)) |=> busy_word[PDT_AON_BIT])
		else $error("always-on busy not set after trigger");

	// Before the domain reset lets go the state field reads off
	AST_STATE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		!por_released |-> (status_word[4:0] == 5'h00))
		else $error("state field not off during domain reset");

	// An override edge survives a clear in the same cycle
	AST_DBG_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
		dbg_event |=> r_reg.irq_stat[PDT_IRQ_DBG])
		else $error("override event lost");

	// A finished transition leaves its completion flag behind
	AST_RAM_DONE_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(ram_busy) |-> r_reg.irq_stat[PDT_IRQ_RAM_DONE])
		else $error("RAM completion flag not set");

	AST_AON_DONE_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(aon_busy) |-> r_reg.irq_stat[PDT_IRQ_AON_DONE])
		else $error("always-on completion flag not set");

	// States move only while their group reports busy
	AST_RAM_MOVE: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(ram_current) |-> $past(ram_busy))
		else $error("RAM state changed outside a transition");

	AST_AON_MOVE: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(aon_mod_state) |-> $past(aon_busy))
		else $error("always-on state changed outside a transition");
endmodule : pdt_ctrl

/* File: testbench/pdt_ctrl_tb.sv */
// Self-checking testbench for the power domain transition controller
`timescale 1ns/100ps
module pdt_ctrl_tb;
	import pdt_pkg::*;

	localparam logic [31:0] STAT_UP  = 32'h00000301; // On, reset released, reset sequence done
	localparam logic [31:0] STAT_MID = 32'h00000101; // On, reset released, sequence still running
	localparam logic [11:0] OFF_HOLE = 12'h100;      // Unmapped word

	logic                    pclk;                       // 10 MHz bus clock
	logic                    presetn;                    // Active-low reset
	logic                    psel;                       // APB select
	logic                    penable;                    // APB access phase
	logic                    pwrite;                     // APB direction
	logic [11:0]             paddr;                      // APB byte address
	logic [31:0]             pwdata;                     // APB write data
	logic [31:0]             prdata;                     // APB read data
	logic                    pready;                     // APB ready
	logic                    pslverr;                    // APB error
	logic                    irq;                        // Level interrupt
	logic [PDT_AON_MODS-1:0] aon_mod_next;               // Always-on module targets
	logic                    ram_domain_next;            // RAM domain target
	logic [PDT_RAM_MODS-1:0] ram_mod_next;               // RAM module targets
	logic                    debug_override_irq_enable;  // Override interrupt enable
	logic                    debug_override_req;         // Override event from debug logic
	logic [PDT_AON_MODS-1:0] aon_mod_state;              // Always-on module states
	logic                    ram_domain_state;           // RAM domain state
	logic [PDT_RAM_MODS-1:0] ram_mod_state;              // RAM module states
	int                      n_errors;                   // Mismatch count
	int                      checks;                     // Comparison count

	pdt_ctrl u_pdt_ctrl (
		.pclk                      (pclk),
		.presetn                   (presetn),
		.psel                      (psel),
		.penable                   (penable),
		.pwrite                    (pwrite),
		.paddr                     (paddr),
		.pwdata                    (pwdata),
		.prdata                    (prdata),
		.pready                    (pready),
		.pslverr                   (pslverr),
		.irq                       (irq),
		.aon_mod_next              (aon_mod_next),
		.ram_domain_next           (ram_domain_next),
		.ram_mod_next              (ram_mod_next),
		.debug_override_irq_enable (debug_override_irq_enable),
		.debug_override_req        (debug_override_req),
		.aon_mod_state             (aon_mod_state),
		.ram_domain_state          (ram_domain_state),
		.ram_mod_state             (ram_mod_state)
	);

	// Free-running clock, half period 50 ns
	initial pclk = 1'b0;
	always #50 pclk = ~pclk;

	// Verdict and end of run; reached from the main sequence or the watchdog
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude

	// Word comparison, case equality so unknowns never match
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk_word

	// Single-bit comparison for flags: irq and the bus error
	task automatic chk_bit(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask : chk_bit

	// APB write: setup, access, hold until pready is seen high
	task automatic apb_write(input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= 1'b1;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb_write

	// APB read: data and error taken at the edge that sees pready high
	task automatic apb_read(input logic [11:0] a, output logic [31:0] d, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		paddr   <= a;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		d = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb_read

	// Read a mapped register and compare, also expecting no bus error
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		logic        e;
		apb_read(a, d, e);
		chk_word(d, exp, what);
		chk_bit(e, 1'b0, "bus error on mapped read");
	endtask : rd_chk

	// Poll busy until clear; a bounded poll so a stuck flag is reported
	task automatic wait_idle;
		logic [31:0] d;
		logic        e;
		int          n;
		d = 32'hFFFFFFFF;
		n = 0;
		while (d !== 32'h0 && n < 20) begin
			apb_read(PDT_OFF_BUSY, d, e);
			n++;
		end
		chk_word(d, 32'h0, "busy after completion");
	endtask : wait_idle

	// Flags and states compared between edges, where they are settled
	task automatic pins_chk(input logic exp_irq, input logic [3:0] aon, input logic [2:0] ram);
		@(negedge pclk);
		chk_bit(irq, exp_irq, "irq");
		chk_word({28'h0, aon_mod_state}, {28'h0, aon}, "always-on module states");
		chk_word({29'h0, ram_domain_state, ram_mod_state}, {29'h0, ram}, "ram domain and module states");
	endtask : pins_chk

	// Watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		conclude();
	end

	// Main sequence
	initial begin
		logic [31:0] d;
		logic        e;
		n_errors = 0;
		checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		aon_mod_next = 4'hF;
		ram_domain_next = 1'b1;
		ram_mod_next = 2'h3;
		debug_override_irq_enable = 1'b0;
		debug_override_req = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;

		// Reset sequence steps and register reset values
		rd_chk(PDT_OFF_STATUS, 32'h0, "status in reset hold");
		repeat (10) @(posedge pclk);
		rd_chk(PDT_OFF_STATUS, STAT_MID, "status after release");
		repeat (20) @(posedge pclk);
		rd_chk(PDT_OFF_STATUS, STAT_UP, "status after sequence");
		rd_chk(PDT_OFF_BUSY, 32'h0, "busy at reset");
		rd_chk(PDT_OFF_IRQ_STAT, 32'h0, "event flags at reset");
		rd_chk(PDT_OFF_IRQ_MASK, 32'h0, "mask at reset");
		$display("test reset done");

		// Zero and reserved-bit writes start nothing despite mismatched targets
		apb_write(PDT_OFF_TRIGGER, 32'h0);
		rd_chk(PDT_OFF_BUSY, 32'h0, "busy after zero write");
		apb_write(PDT_OFF_TRIGGER, 32'hFFFFFFFC);
		rd_chk(PDT_OFF_BUSY, 32'h0, "busy after reserved write");
		rd_chk(PDT_OFF_TRIGGER, 32'h0, "trigger readback");
		pins_chk(1'b0, 4'h0, 3'h0);
		$display("test no_trigger done");

		// RAM group moves domain and modules, always-on untouched
		apb_write(PDT_OFF_TRIGGER, 32'h2);
		rd_chk(PDT_OFF_BUSY, 32'h2, "ram busy");
		wait_idle();
		pins_chk(1'b0, 4'h0, 3'h7);
		$display("test ram_group done");

		// Always-on group moves modules only; status shows transition
		apb_write(PDT_OFF_TRIGGER, 32'h1);
		rd_chk(PDT_OFF_BUSY, 32'h1, "always-on busy");
		wait_idle();
		pins_chk(1'b0, 4'hF, 3'h7);
		@(posedge pclk);
		aon_mod_next <= 4'h5;
		apb_write(PDT_OFF_TRIGGER, 32'h1);
		rd_chk(PDT_OFF_STATUS, 32'h310, "status in transition");
		wait_idle();
		rd_chk(PDT_OFF_STATUS, STAT_UP, "status back on");
		pins_chk(1'b0, 4'h5, 3'h7);
		$display("test aon_group done");

		// Matching targets leave things alone; only the odd module moves
		apb_write(PDT_OFF_TRIGGER, 32'h2);
		rd_chk(PDT_OFF_BUSY, 32'h0, "busy with nothing to move");
		ram_mod_next <= 2'h1;
		apb_write(PDT_OFF_TRIGGER, 32'h2);
		wait_idle();
		pins_chk(1'b0, 4'h5, 3'h5);
		$display("test partial done");

		// Unmapped address answers with an error and reads zero
		apb_read(OFF_HOLE, d, e);
		chk_word(d, 32'h0, "unmapped read data");
		chk_bit(e, 1'b1, "unmapped error");
		apb_write(OFF_HOLE, 32'hFFFFFFFF);
		$display("test unmapped done");

		// Completion events: mask, then clear one at a time
		rd_chk(PDT_OFF_IRQ_STAT, 32'h3, "completion flags");
		apb_write(PDT_OFF_IRQ_MASK, 32'h3);
		rd_chk(PDT_OFF_IRQ_MASK, 32'h3, "mask readback");
		pins_chk(1'b1, 4'h5, 3'h5);
		apb_write(PDT_OFF_IRQ_STAT, 32'h1);
		pins_chk(1'b1, 4'h5, 3'h5);
		apb_write(PDT_OFF_IRQ_STAT, 32'h2);
		pins_chk(1'b0, 4'h5, 3'h5);
		rd_chk(PDT_OFF_IRQ_STAT, 32'h0, "flags after clear");
		$display("test completion_irq done");

		// Debug override flag, gated by its enable
		apb_write(PDT_OFF_IRQ_MASK, 32'h4);
		@(posedge pclk);
		debug_override_req <= 1'b1;
		repeat (6) @(posedge pclk);
		debug_override_req <= 1'b0;
		rd_chk(PDT_OFF_STATUS, 32'hB01, "override flag set");
		pins_chk(1'b0, 4'h5, 3'h5);
		@(posedge pclk);
		debug_override_irq_enable <= 1'b1;
		pins_chk(1'b1, 4'h5, 3'h5);
		apb_write(PDT_OFF_IRQ_STAT, 32'h4);
		pins_chk(1'b0, 4'h5, 3'h5);
		rd_chk(PDT_OFF_STATUS, STAT_UP, "override flag cleared");
		$display("test debug_override done");

		conclude();
	end
endmodule : pdt_ctrl_tb
